// [core/pbc_bank.sv]
// identification words and primary command register of the bridge header
//
// How it works
// R1: the low half of the first word is a fixed vendor code that writes never change.
// R2: the high half of the first word is a fixed device code that writes never change.
// R3: command bit 0 resets low and gates claiming of primary I/O cycles.
// R4: command bit 1 resets low and gates claiming of primary memory cycles.
// R5: command bit 2 resets low and gates primary mastering and secondary claims.
// R6: command bit 3 is fixed at zero.
// R7: command bit 4 is fixed at zero.
// R8: command bit 5 enables claiming primary I/O writes to palette ports 3C6h, 3C8h, 3C9h.
// R9: command bit 6 resets low and decides whether detected parity errors are acted on.
// R10: command bit 7 is fixed at zero, so the primary stepping enable stays off.
// R11: command bit 8 resets low and enables the system error pin driver.
// R12: command bit 9 resets low and allows fast back-to-back cycles on the primary bus.
// R13: command bits 15:10 always read zero.
// R14: writes to fixed bits are dropped while writable bits follow byte enables.
//
// The strobed register port is this design's own decision.
`default_nettype none
`include "pbc_regs.svh"
module pbc_bank #(
	// arbitrary neutral identification values
	parameter logic [15:0] VENDOR_CODE = 16'hA5A5,
	parameter logic [15:0] DEVICE_CODE = 16'h5A5A
) (
	// clock and reset
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RST_N_I,
	// register port
	input  wire logic [`PBC_ADDR_W-1:0]  REG_ADDR_I,
	input  wire logic [31:0]             REG_WDATA_I,
	input  wire logic [3:0]              REG_BE_I,
	input  wire logic                    REG_WR_I,
	input  wire logic                    REG_RD_I,
	output logic      [31:0]             REG_RDATA_O,
	// primary target decode
	input  wire pbc_pkg::pbc_pri_req_t   PRI_REQ_I,
	output logic                         PRI_CLAIM_O,
	output logic                         PRI_VGA_HIT_O,
	// secondary target decode
	input  wire pbc_pkg::pbc_sec_req_t   SEC_REQ_I,
	output logic                         SEC_CLAIM_O,
	// primary master qualifiers
	output logic                         PRI_MASTER_EN_O,
	output logic                         PRI_FB2B_EN_O,
	output logic                         STEP_EN_O,
	// parity handling
	input  wire logic                    PAR_ERR_DET_I,
	output logic                         PAR_ERR_REPORT_O,
	// system error pin, open drain
	input  wire logic                    SERR_REQ_I,
	output logic                         PRIMARY_SYSTEM_ERROR_OUT_N_O,
	output logic                         PRIMARY_SYSTEM_ERROR_OUT_N_OE_O
);

	pbc_pkg::pbc_state_t state_q;
	pbc_pkg::pbc_state_t state_d;
	logic [15:0]         cmd_bits;
	logic [15:0]         be_mask;

	// only writable positions survive, whatever the write data holds
	function automatic logic [15:0] merge_cmd(input logic [15:0] old_v,
		input logic [15:0] wr_v, input logic [15:0] lanes);
		logic [15:0] take;
		take      = lanes & `PBC_CMD_WR_MASK;
		merge_cmd = (old_v & ~take) | (wr_v & take);
	endfunction

	always_comb begin
		state_d  = state_q;
		be_mask  = {{8{REG_BE_I[1]}}, {8{REG_BE_I[0]}}};
		cmd_bits = state_q.cmd;
		if (REG_WR_I && (REG_ADDR_I == `PBC_OFF_CMD)) begin
			state_d.cmd = merge_cmd(cmd_bits, REG_WDATA_I[15:0], be_mask); // R14
		end
		// writes to the identity word fall through untouched
		state_d.cmd.special = 1'b0; // R6
		state_d.cmd.mwi     = 1'b0; // R7
		state_d.cmd.step    = 1'b0; // R10
		state_d.cmd.rsvd    = '0; // R13
		state_d.rdata = `PBC_WORD_ZERO;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				`PBC_OFF_ID:  state_d.rdata = {DEVICE_CODE, VENDOR_CODE}; // R1 R2
				`PBC_OFF_CMD: state_d.rdata = {`PBC_HALF_ZERO, state_q.cmd};
				default:      state_d.rdata = `PBC_WORD_ZERO;
			endcase
		end
		// error reports masked here rather than at the source
		state_d.par_report = PAR_ERR_DET_I && state_q.cmd.par_resp; // R9
		state_d.serr_oe    = SERR_REQ_I && state_q.cmd.serr_en; // R11
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q.cmd        <= `PBC_CMD_RST;
			state_q.rdata      <= `PBC_WORD_ZERO;
			state_q.par_report <= 1'b0;
			state_q.serr_oe    <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	pbc_decode u_decode (
		.cmd_valid_i (1'b1),
		.cmd_i       (state_q.cmd),
		.pri_i       (PRI_REQ_I),
		.sec_i       (SEC_REQ_I),
		.pri_claim_o (PRI_CLAIM_O),
		.vga_hit_o   (PRI_VGA_HIT_O),
		.sec_claim_o (SEC_CLAIM_O)
	);

	assign REG_RDATA_O                     = state_q.rdata;
	assign PRI_MASTER_EN_O                 = state_q.cmd.bme; // R5
	assign PRI_FB2B_EN_O                   = state_q.cmd.fb2b; // R12
	assign STEP_EN_O                       = state_q.cmd.step; // R10
	assign PAR_ERR_REPORT_O                = state_q.par_report;
	// pin only ever pulls low; the board pull-up gives the high level
	assign PRIMARY_SYSTEM_ERROR_OUT_N_O    = 1'b0;
	assign PRIMARY_SYSTEM_ERROR_OUT_N_OE_O = state_q.serr_oe; // R11

endmodule // pbc_bank
`default_nettype wire

// [core/pbc_decode.sv]
// transaction claim decode gated by the command enables
`default_nettype none
`include "pbc_regs.svh"
module pbc_decode (
	// command enables
	input  wire logic              cmd_valid_i,
	input  wire pbc_pkg::pbc_cmd_t cmd_i,
	// bus requests
	input  wire pbc_pkg::pbc_pri_req_t pri_i,
	input  wire pbc_pkg::pbc_sec_req_t sec_i,
	// claims
	output logic                   pri_claim_o,
	output logic                   vga_hit_o,
	output logic                   sec_claim_o
);

	// upper bits are ISA aliases and are deliberately not compared
	function automatic logic is_palette(input logic [9:0] a);
		is_palette = (a == `PBC_VGA_A0) || (a == `PBC_VGA_A1) || (a == `PBC_VGA_A2);
	endfunction

	logic io_hit;
	logic mem_hit;

	always_comb begin
		io_hit      = pri_i.valid && pri_i.is_io && pri_i.in_window && cmd_i.io; // R3
		mem_hit     = pri_i.valid && pri_i.is_mem && pri_i.in_window && cmd_i.mem; // R4
		vga_hit_o   = cmd_valid_i && pri_i.valid && pri_i.is_io && pri_i.is_write
			&& cmd_i.vga && is_palette(pri_i.addr[9:0]); // R8
		pri_claim_o = cmd_valid_i && (io_hit || mem_hit || vga_hit_o);
		sec_claim_o = cmd_valid_i && sec_i.valid && sec_i.is_memio
			&& sec_i.in_window && cmd_i.bme; // R5
	end

endmodule // pbc_decode
`default_nettype wire

// [core/pbc_pkg.sv]
// types shared by the bridge command bank and its decoder
`default_nettype none
package pbc_pkg;

	typedef struct packed {
		logic [5:0] rsvd;
		logic       fb2b;
		logic       serr_en;
		logic       step;
		logic       par_resp;
		logic       vga;
		logic       mwi;
		logic       special;
		logic       bme;
		logic       mem;
		logic       io;
	} pbc_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic        is_mem;
		logic        is_write;
		logic        in_window;
		logic [31:0] addr;
	} pbc_pri_req_t;

	typedef struct packed {
		logic valid;
		logic is_memio;
		logic in_window;
	} pbc_sec_req_t;

	typedef struct packed {
		pbc_cmd_t    cmd;
		logic [31:0] rdata;
		logic        par_report;
		logic        serr_oe;
	} pbc_state_t;

endpackage : pbc_pkg
`default_nettype wire

// [core/pbc_regs.svh]
// offsets, field positions, reset values and decode constants for the bridge command bank
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

`define PBC_ADDR_W      8
`define PBC_OFF_ID      8'h00
`define PBC_OFF_CMD     8'h04

`define PBC_CMD_IO      0
`define PBC_CMD_MEM     1
`define PBC_CMD_BME     2
`define PBC_CMD_SPC     3
`define PBC_CMD_MWI     4
`define PBC_CMD_VGA     5
`define PBC_CMD_PAR     6
`define PBC_CMD_STEP    7
`define PBC_CMD_SERR    8
`define PBC_CMD_FB2B    9

`define PBC_CMD_RST     16'h0000
`define PBC_CMD_WR_MASK 16'h0367

`define PBC_VGA_A0      10'h3C6
`define PBC_VGA_A1      10'h3C8
`define PBC_VGA_A2      10'h3C9

`define PBC_WORD_ZERO   32'h0000_0000
`define PBC_HALF_ZERO   16'h0000

`endif

// [verif/pbc_bank_assertions.sv]
// port-level checker for the bridge command bank
`default_nettype none
module pbc_bank_chk #(
	parameter logic [15:0] VENDOR_CODE = 16'hA5A5,
	parameter logic [15:0] DEVICE_CODE = 16'h5A5A
) (
	input wire logic SYS_CLK_I, RST_N_I, REG_WR_I, REG_RD_I, PRI_CLAIM_O, PRI_VGA_HIT_O,
	input wire logic SEC_CLAIM_O, PRI_MASTER_EN_O, PRI_FB2B_EN_O, STEP_EN_O, PAR_ERR_DET_I,
	input wire logic PAR_ERR_REPORT_O, SERR_REQ_I, PRIMARY_SYSTEM_ERROR_OUT_N_O,
	input wire logic PRIMARY_SYSTEM_ERROR_OUT_N_OE_O,
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I, REG_RDATA_O,
	input wire logic [3:0]  REG_BE_I,
	input wire pbc_pkg::pbc_pri_req_t PRI_REQ_I,
	input wire pbc_pkg::pbc_sec_req_t SEC_REQ_I
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire logic [9:0] pa = PRI_REQ_I.addr[9:0];
	chk_id_word: assert property (REG_RD_I && REG_ADDR_I == 8'h00 |=>
		REG_RDATA_O == {DEVICE_CODE, VENDOR_CODE}) else $error("id word wrong");
	chk_cmd_fixed: assert property (REG_RD_I && REG_ADDR_I == 8'h04 |=>
		(REG_RDATA_O & ~32'h0000_0367) == 32'h0) else $error("fixed bits set");
	chk_rdata_idle: assert property (!(REG_RD_I && REG_ADDR_I inside {8'h00, 8'h04}) |=>
		REG_RDATA_O == 32'h0) else $error("stray read data");
	chk_master_wr: assert property (REG_WR_I && REG_ADDR_I == 8'h04 && REG_BE_I[0] |=>
		PRI_MASTER_EN_O == $past(REG_WDATA_I[2])) else $error("master enable stale");
	chk_fb2b_wr: assert property (REG_WR_I && REG_ADDR_I == 8'h04 && REG_BE_I[1] |=>
		PRI_FB2B_EN_O == $past(REG_WDATA_I[9])) else $error("fast b2b stale");
	chk_step_off: assert property (STEP_EN_O == 1'b0) else $error("stepping on");
	chk_sec_gate: assert property (SEC_CLAIM_O == (SEC_REQ_I.valid && SEC_REQ_I.is_memio
		&& SEC_REQ_I.in_window && PRI_MASTER_EN_O)) else $error("secondary claim wrong");
	chk_vga_cause: assert property (PRI_VGA_HIT_O |-> PRI_CLAIM_O && PRI_REQ_I.valid &&
		PRI_REQ_I.is_io && PRI_REQ_I.is_write && pa inside {10'h3C6, 10'h3C8, 10'h3C9})
		else $error("palette hit wrong");
	chk_par_gate: assert property (PAR_ERR_REPORT_O |-> $past(PAR_ERR_DET_I))
		else $error("parity report uncaused");
	chk_serr_pin: assert property (PRIMARY_SYSTEM_ERROR_OUT_N_OE_O |-> $past(SERR_REQ_I) &&
		PRIMARY_SYSTEM_ERROR_OUT_N_O == 1'b0) else $error("error pin uncaused");
endmodule // pbc_bank_chk
`default_nettype wire

// [verif/pbc_host.sv]
// configuration host model driving the register port
`default_nettype none
module pbc_host (
	input  wire logic        clk_i,
	output logic      [7:0]  addr_o,
	output logic      [31:0] wdata_o,
	output logic      [3:0]  be_o,
	output logic             wr_o,
	output logic             rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {addr_o, wdata_o, be_o, wr_o, rd_o} = '0;
	// released data flips so a stale sample cannot look valid
	task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk_i);
		{addr_o, wdata_o, be_o, wr_o, rd_o} <= {a, d, b, w, !w};
		@(posedge clk_i);
		{wdata_o, wr_o, rd_o} <= {~d, 2'b00};
	endtask
endmodule // pbc_host
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the bridge command bank
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic SYS_CLK_I = 0, RST_N_I = 0, REG_WR_I, REG_RD_I, PAR_ERR_DET_I = 0, SERR_REQ_I = 0;
	logic [7:0] REG_ADDR_I;
	logic [31:0] REG_WDATA_I, REG_RDATA_O, exp_q[$];
	logic [3:0] REG_BE_I;
	logic [15:0] cmd = 16'h0000;
	logic PRI_CLAIM_O, PRI_VGA_HIT_O, SEC_CLAIM_O, PRI_MASTER_EN_O, PRI_FB2B_EN_O, STEP_EN_O,
		PAR_ERR_REPORT_O, PRIMARY_SYSTEM_ERROR_OUT_N_O, PRIMARY_SYSTEM_ERROR_OUT_N_OE_O;
	pbc_pkg::pbc_pri_req_t PRI_REQ_I = '0;
	pbc_pkg::pbc_sec_req_t SEC_REQ_I = '0;
	int bad_count = 0, total_checks = 0;
	always #2.5 SYS_CLK_I = ~SYS_CLK_I;
	pbc_host pbc_host_i (.clk_i(SYS_CLK_I), .addr_o(REG_ADDR_I), .wdata_o(REG_WDATA_I),
		.be_o(REG_BE_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I));
	pbc_bank #(.VENDOR_CODE(16'h1234), .DEVICE_CODE(16'h9876)) pbc_bank_i (.*);
	task automatic chk(input string n, input logic [31:0] x, y);
		total_checks++;
		if (x !== y) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		pbc_host_i.op(0, a, 32'h0, 4'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		logic [15:0] m = {{8{b[1]}}, {8{b[0]}}} & 16'h0367;
		if (a == 8'h04) cmd = (cmd & ~m) | (d[15:0] & m);
		pbc_host_i.op(1, a, d, b);
	endtask
	task automatic stim;
		pbc_pkg::pbc_pri_req_t p = {5'($urandom), $urandom};
		pbc_pkg::pbc_sec_req_t s = 3'($urandom);
		logic d = 1'($urandom), q = 1'($urandom), h, c;
		if (p.addr[31]) p.addr[9:0] = p.addr[10] ? 10'h3C6 : (p.addr[11] ? 10'h3C8 : 10'h3C9);
		h = p.valid & p.is_io & p.is_write & cmd[5]
			& (p.addr[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9});
		c = p.valid & p.in_window & (p.is_io & cmd[0] | p.is_mem & cmd[1]) | h;
		@(posedge SYS_CLK_I);
		{PRI_REQ_I, SEC_REQ_I, PAR_ERR_DET_I, SERR_REQ_I} <= {p, s, d, q};
		@(posedge SYS_CLK_I);
		#1 chk("vga", h, PRI_VGA_HIT_O);
		chk("claim", c, PRI_CLAIM_O);
		chk("sec", &{s, cmd[2]}, SEC_CLAIM_O);
		chk("par", d & cmd[6], PAR_ERR_REPORT_O);
		chk("serr", {q & cmd[8], 1'b0},
			{PRIMARY_SYSTEM_ERROR_OUT_N_OE_O, PRIMARY_SYSTEM_ERROR_OUT_N_O});
		chk("mode", {cmd[2], cmd[9], 1'b0},
			{PRI_MASTER_EN_O, PRI_FB2B_EN_O, STEP_EN_O});
	endtask
	always @(posedge SYS_CLK_I) if (REG_RD_I === 1'b1) begin
		#1 chk("rdata", exp_q.pop_front(), REG_RDATA_O);
	end
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'hEC6AC0CE));
		repeat (20) @(posedge SYS_CLK_I);
		RST_N_I <= 1'b1;
		rd(8'h04, 32'h0);
		wr(8'h00, 32'hFFFF_FFFF, 4'hF);
		wr(8'h10, 32'hFFFF_FFFF, 4'hF);
		rd(8'h00, 32'h9876_1234);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'hFFFF_FFFF, 4'h3);
		rd(8'h04, 32'h0000_0367);
		repeat (150) begin
			wr(8'h04, $urandom, 4'($urandom));
			rd(8'h04, {16'h0, cmd});
			stim();
		end
		// mid-run reset must clear every writable enable again
		RST_N_I <= 1'b0;
		cmd = 16'h0000;
		repeat (2) @(posedge SYS_CLK_I);
		#1 chk("rst", 4'h0, {PRI_MASTER_EN_O, PRI_FB2B_EN_O,
			PAR_ERR_REPORT_O, PRIMARY_SYSTEM_ERROR_OUT_N_OE_O});
		@(posedge SYS_CLK_I);
		RST_N_I <= 1'b1;
		rd(8'h04, 32'h0);
		repeat (4) stim();
		end_of_test();
	end
endmodule // tb_top
bind pbc_bank pbc_bank_chk #(.VENDOR_CODE(VENDOR_CODE), .DEVICE_CODE(DEVICE_CODE))
	pbc_bank_chk_i (.*);
`default_nettype wire
